// >>> hdl/ppo_port.sv
module ppo_port #(
    parameter int RES_REFRESH_CYC = ppo_pkg::RES_REFRESH_CYC,
    parameter int LDT_REFRESH_CYC = ppo_pkg::LDT_REFRESH_CYC,
    parameter int SETTLE_CYC = ppo_pkg::SETTLE_CYC
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic meas_valid,
    output logic meas_ready,
    input wire ppo_pkg::ppo_meas_t meas,
    input wire logic par_strobe,
    output logic [ppo_pkg::WORD_W-1:0] par_word,
    output logic par_load
);

    localparam int W = ppo_pkg::WORD_W;
    localparam int CW = ppo_pkg::REFRESH_CNT_W;

    if ((W % 4) != 0 || W < 4)
    begin : g_bad_word
        $error("ppo_port: word width must be a positive multiple of four");
    end
    if (RES_REFRESH_CYC < 1 || RES_REFRESH_CYC > (2 ** CW))
    begin : g_bad_res
        $error("ppo_port: resolver refresh count out of range");
    end
    if (LDT_REFRESH_CYC < 1 || LDT_REFRESH_CYC > (2 ** CW))
    begin : g_bad_ldt
        $error("ppo_port: transducer refresh count out of range");
    end
    // Edge-to-word latency must fit in the reader's settling wait
    if (SETTLE_CYC < ppo_pkg::SYNC_LAT_CYC)
    begin : g_bad_settle
        $error("ppo_port: settling count shorter than strobe latency");
    end

    localparam logic [CW-1:0] RES_RELOAD = CW'(RES_REFRESH_CYC - 1);
    localparam logic [CW-1:0] LDT_RELOAD = CW'(LDT_REFRESH_CYC - 1);

    ppo_pkg::ppo_state_t st_q;
    ppo_pkg::ppo_state_t st_d;

    logic buf_valid;
    logic buf_ready;
    ppo_pkg::ppo_meas_t buf_data;
    logic [W-1:0] src_w;
    logic [W-1:0] gray_w;
    logic [W-1:0] bcd_w;
    logic [W-1:0] coded_w;
    logic hold;
    logic strb_edge;
    logic strb_fall;
    logic tick;
    logic load;
    logic addr_take;

    // Overflow saturates to all nines rather than wrapping to a wrong number
    function automatic logic [W-1:0] to_bcd(input logic [W-1:0] b);
        logic [2*W-1:0] sh;
        sh = {{W{1'b0}}, b};
        for (int k = 0; k < W; k++)
        begin
            for (int d = 0; d < W / 4; d++)
            begin
                if (sh[W + 4 * d +: 4] >= 4'h5)
                begin
                    sh[W + 4 * d +: 4] = sh[W + 4 * d +: 4] + 4'h3;
                end
            end
            sh = {sh[2*W-2:0], 1'b0};
        end
        if (b > ppo_pkg::BCD_MAX)
        begin
            sh[2*W-1:W] = {ppo_pkg::BCD_DIGITS{4'h9}};
        end
        return sh[2*W-1:W];
    endfunction

    // Stalls while latched, so samples back up into the buffer, not lost
    ppo_buf #(
        .DATA_W($bits(ppo_pkg::ppo_meas_t))
    ) u_buf (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .in_valid(meas_valid),
        .in_ready(meas_ready),
        .in_data(meas),
        .out_valid(buf_valid),
        .out_ready(buf_ready),
        .out_data(buf_data)
    );

    assign src_w = st_q.ctrl.src_vel ? st_q.latest.vel : st_q.latest.pos;

    genvar gi;
    for (gi = 0; gi < W - 1; gi++)
    begin : g_gray
        assign gray_w[gi] = src_w[gi] ^ src_w[gi + 1];
    end
    assign gray_w[W-1] = src_w[W-1];

    assign bcd_w = to_bcd(src_w);

    always_comb
    begin
        case (st_q.ctrl.fmt)
            ppo_pkg::FMT_BCD:
            begin
                coded_w = bcd_w;
            end
            ppo_pkg::FMT_GRAY:
            begin
                coded_w = gray_w;
            end
            default:
            begin
                coded_w = src_w;
            end
        endcase
    end

    // Only the synchronized copies are looked at
    assign strb_edge = st_q.strb_sync ^ st_q.strb_prev;
    assign strb_fall = st_q.strb_prev && !st_q.strb_sync;
    assign hold = st_q.ctrl.strb_en && !st_q.ctrl.hs_mode && st_q.strb_sync;
    assign buf_ready = !hold;
    assign tick = (st_q.cnt == '0);

    always_comb
    begin
        load = 1'b0;
        if (!st_q.ctrl.strb_en)
        begin
            load = tick;
        end
        else if (st_q.ctrl.hs_mode)
        begin
            // Relies on the controller keeping the square wave going
            load = strb_edge;
        end
        else
        begin
            // Release waits for the buffer to drain so the word is current
            load = !hold && ((tick && !st_q.rel_pend) || (st_q.rel_pend && !buf_valid));
        end
    end

    assign addr_take = hsel && hready && htrans[1];

    always_comb
    begin
        st_d = st_q;
        st_d.hreadyout = 1'b1;
        st_d.hresp = 1'b0;
        st_d.par_load = 1'b0;

        st_d.strb_meta = par_strobe;
        st_d.strb_sync = st_q.strb_meta;
        st_d.strb_prev = st_q.strb_sync;

        if (tick)
        begin
            st_d.cnt = st_q.ctrl.ldt ? LDT_RELOAD : RES_RELOAD;
        end
        else
        begin
            st_d.cnt = st_q.cnt - CW'(1);
        end

        if (buf_valid && buf_ready)
        begin
            st_d.latest = buf_data;
            st_d.latest_ok = 1'b1;
        end

        if (strb_fall && st_q.ctrl.strb_en && !st_q.ctrl.hs_mode)
        begin
            st_d.rel_pend = 1'b1;
        end
        else if (load)
        begin
            st_d.rel_pend = 1'b0;
        end

        // Clear by software and a load in the same cycle leave the count at one
        if (st_q.bus_st == ppo_pkg::BUS_WRITE && st_q.bus_addr == ppo_pkg::ADDR_COUNT)
        begin
            st_d.upd_cnt = '0;
        end
        if (load)
        begin
            st_d.par_word = coded_w;
            st_d.par_load = 1'b1;
            st_d.upd_cnt = st_d.upd_cnt + 16'h0001;
        end

        if (st_q.bus_st == ppo_pkg::BUS_WRITE && st_q.bus_addr == ppo_pkg::ADDR_CTRL)
        begin
            st_d.ctrl.src_vel = hwdata[ppo_pkg::CTRL_SRC_BIT];
            st_d.ctrl.hs_mode = hwdata[ppo_pkg::CTRL_MODE_BIT];
            st_d.ctrl.strb_en = hwdata[ppo_pkg::CTRL_STRB_EN_BIT];
            st_d.ctrl.ldt = hwdata[ppo_pkg::CTRL_LDT_BIT];
            case (hwdata[ppo_pkg::CTRL_FMT_LSB +: 2])
                2'b01:
                begin
                    st_d.ctrl.fmt = ppo_pkg::FMT_BCD;
                end
                2'b10:
                begin
                    st_d.ctrl.fmt = ppo_pkg::FMT_GRAY;
                end
                default:
                begin
                    st_d.ctrl.fmt = ppo_pkg::FMT_BIN;
                end
            endcase
        end

        st_d.bus_st = ppo_pkg::BUS_IDLE;
        if (addr_take && hsize == ppo_pkg::HSIZE_WORD)
        begin
            st_d.bus_addr = haddr[7:0];
            st_d.bus_st = hwrite ? ppo_pkg::BUS_WRITE : ppo_pkg::BUS_READ;
        end

        // Read data taken from the updated control, so write-then-read is coherent
        st_d.hrdata = 32'h0000_0000;
        if (addr_take && !hwrite && hsize == ppo_pkg::HSIZE_WORD && haddr[31:8] == 24'h000000)
        begin
            case (haddr[7:0])
                ppo_pkg::ADDR_CTRL:
                begin
                    st_d.hrdata[ppo_pkg::CTRL_SRC_BIT] = st_d.ctrl.src_vel;
                    st_d.hrdata[ppo_pkg::CTRL_FMT_LSB +: 2] = st_d.ctrl.fmt;
                    st_d.hrdata[ppo_pkg::CTRL_MODE_BIT] = st_d.ctrl.hs_mode;
                    st_d.hrdata[ppo_pkg::CTRL_STRB_EN_BIT] = st_d.ctrl.strb_en;
                    st_d.hrdata[ppo_pkg::CTRL_LDT_BIT] = st_d.ctrl.ldt;
                end
                ppo_pkg::ADDR_STATUS:
                begin
                    st_d.hrdata[ppo_pkg::STAT_STRB_BIT] = st_q.strb_sync;
                    st_d.hrdata[ppo_pkg::STAT_HOLD_BIT] = hold;
                    st_d.hrdata[ppo_pkg::STAT_BUF_BIT] = buf_valid;
                    st_d.hrdata[ppo_pkg::STAT_DATA_BIT] = st_q.latest_ok;
                    st_d.hrdata[ppo_pkg::STAT_PEND_BIT] = st_q.rel_pend;
                end
                ppo_pkg::ADDR_WORD:
                begin
                    st_d.hrdata[W-1:0] = st_q.par_word;
                end
                ppo_pkg::ADDR_COUNT:
                begin
                    st_d.hrdata[ppo_pkg::UPD_CNT_W-1:0] = st_q.upd_cnt;
                end
                default:
                begin
                    st_d.hrdata = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            st_q <= ppo_pkg::ST_RST;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign hrdata = st_q.hrdata;
    assign hreadyout = st_q.hreadyout;
    assign hresp = st_q.hresp;
    assign par_word = st_q.par_word;
    assign par_load = st_q.par_load;

endmodule // ppo_port

// >>> hdl/ppo_pkg.sv
package ppo_pkg;

    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int RES_REFRESH_US = 50;
    localparam int RES_REFRESH_CYC = RES_REFRESH_US * 1000 / CLK_PERIOD_NS;
    localparam int LDT_REFRESH_MS = 40;
    localparam int LDT_REFRESH_CYC = LDT_REFRESH_MS * 1000000 / CLK_PERIOD_NS;
    localparam int SETTLE_US = 100;
    localparam int SETTLE_CYC = SETTLE_US * 1000 / CLK_PERIOD_NS;
    localparam int SYNC_LAT_CYC = 3;
    localparam int REFRESH_CNT_W = 23;

    // Output word
    localparam int WORD_W = 16;
    localparam int BCD_DIGITS = WORD_W / 4;
    localparam logic [WORD_W-1:0] BCD_MAX = 16'h270f;
    localparam int UPD_CNT_W = 16;

    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_WORD = 8'h08;
    localparam logic [7:0] ADDR_COUNT = 8'h0c;

    // Control field positions
    localparam int CTRL_SRC_BIT = 0;
    localparam int CTRL_FMT_LSB = 1;
    localparam int CTRL_MODE_BIT = 3;
    localparam int CTRL_STRB_EN_BIT = 4;
    localparam int CTRL_LDT_BIT = 5;

    // Status field positions
    localparam int STAT_STRB_BIT = 0;
    localparam int STAT_HOLD_BIT = 1;
    localparam int STAT_BUF_BIT = 2;
    localparam int STAT_DATA_BIT = 3;
    localparam int STAT_PEND_BIT = 4;

    localparam logic [2:0] HSIZE_WORD = 3'h2;

    typedef enum logic [1:0] {
        FMT_BIN = 2'b00,
        FMT_BCD = 2'b01,
        FMT_GRAY = 2'b10
    } ppo_fmt_t;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_WRITE = 2'b01,
        BUS_READ = 2'b10
    } ppo_bus_st_t;

    typedef struct packed {
        logic ldt;
        logic strb_en;
        logic hs_mode;
        ppo_fmt_t fmt;
        logic src_vel;
    } ppo_ctrl_t;

    typedef struct packed {
        logic [WORD_W-1:0] pos;
        logic [WORD_W-1:0] vel;
    } ppo_meas_t;

    typedef struct packed {
        ppo_bus_st_t bus_st;
        logic [7:0] bus_addr;
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
        ppo_ctrl_t ctrl;
        logic strb_meta;
        logic strb_sync;
        logic strb_prev;
        ppo_meas_t latest;
        logic latest_ok;
        logic rel_pend;
        logic [WORD_W-1:0] par_word;
        logic par_load;
        logic [REFRESH_CNT_W-1:0] cnt;
        logic [UPD_CNT_W-1:0] upd_cnt;
    } ppo_state_t;

    localparam ppo_ctrl_t CTRL_RST = '{
        ldt: 1'b0, strb_en: 1'b0, hs_mode: 1'b0, fmt: FMT_BIN, src_vel: 1'b0};

    localparam ppo_state_t ST_RST = '{
        bus_st: BUS_IDLE,
        bus_addr: 8'h00,
        hrdata: 32'h0000_0000,
        hreadyout: 1'b0,
        hresp: 1'b0,
        ctrl: CTRL_RST,
        strb_meta: 1'b0,
        strb_sync: 1'b0,
        strb_prev: 1'b0,
        latest: '{pos: 16'h0000, vel: 16'h0000},
        latest_ok: 1'b0,
        rel_pend: 1'b0,
        par_word: 16'h0000,
        par_load: 1'b0,
        cnt: 23'h000000,
        upd_cnt: 16'h0000};

endpackage

// >>> hdl/ppo_buf.sv
module ppo_buf #(
    parameter int DATA_W = 32
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [DATA_W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [DATA_W-1:0] out_data
);

    typedef struct packed {
        logic [1:0][DATA_W-1:0] mem;
        logic wr_ptr;
        logic rd_ptr;
        logic [1:0] count;
        logic in_rdy;
    } ppo_buf_st_t;

    ppo_buf_st_t st_q;
    ppo_buf_st_t st_d;
    logic push;
    logic pop;

    if (DATA_W < 1)
    begin : g_bad_width
        $error("ppo_buf: DATA_W must be at least 1");
    end

    assign push = in_valid && st_q.in_rdy;
    assign pop = (st_q.count != 2'd0) && out_ready;

    always_comb
    begin
        st_d = st_q;
        if (push)
        begin
            st_d.mem[st_q.wr_ptr] = in_data;
            st_d.wr_ptr = ~st_q.wr_ptr;
        end
        if (pop)
        begin
            st_d.rd_ptr = ~st_q.rd_ptr;
        end
        if (push && !pop)
        begin
            st_d.count = st_q.count + 2'd1;
        end
        else if (pop && !push)
        begin
            st_d.count = st_q.count - 2'd1;
        end
        // Ready registered so the source sees a clean flop
        st_d.in_rdy = (st_d.count != 2'd2);
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            st_q <= '{mem: '0, wr_ptr: 1'b0, rd_ptr: 1'b0, count: 2'd0, in_rdy: 1'b0};
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign in_ready = st_q.in_rdy;
    assign out_valid = (st_q.count != 2'd0);
    assign out_data = st_q.mem[st_q.rd_ptr];

endmodule // ppo_buf

// >>> bench/ppo_port_assertions.sv
module ppo_port_chk #(
    parameter int RES_REFRESH_CYC = 20,
    parameter int LDT_REFRESH_CYC = 50,
    parameter int SETTLE_CYC = 3
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic par_strobe,
    input wire logic [ppo_pkg::WORD_W-1:0] par_word,
    input wire logic par_load
);
    logic wr_q, meta_q, sync_q, chg_q;
    logic [5:0] ctrl_q;
    logic [31:0] gap_q;
    wire latch_w = ctrl_q[4] && !ctrl_q[3];
    wire hs_w = ctrl_q[4] && ctrl_q[3];
    default clocking dc @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);
    // Period judged only after a load under steady free run, since changes apply at reload
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            wr_q <= 1'b0;
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            chg_q <= 1'b1;
            ctrl_q <= 6'h00;
            gap_q <= 32'h0;
        end
        else
        begin
            wr_q <= hsel && hready && htrans[1] && hwrite && haddr == 32'h0 && hsize == 3'h2;
            ctrl_q <= wr_q ? hwdata[5:0] : ctrl_q;
            meta_q <= par_strobe;
            sync_q <= meta_q;
            gap_q <= par_load ? 32'h1 : gap_q + 32'h1;
            chg_q <= (chg_q && !par_load) || wr_q || ctrl_q[4];
        end
    end
    sequence hs_edge_s;
        hs_w && $changed(par_strobe);
    endsequence
    sequence hs_load_s;
        !par_load [*2] ##1 par_load;
    endsequence
    free_res_a: assert property (
        par_load && !chg_q && !ctrl_q[5] |-> gap_q == RES_REFRESH_CYC)
        else $error("resolver refresh period wrong");
    free_ldt_a: assert property (
        par_load && !chg_q && ctrl_q[5] |-> gap_q == LDT_REFRESH_CYC)
        else $error("transducer refresh period wrong");
    latch_hold_a: assert property (latch_w && sync_q |=> !par_load)
        else $error("load while latch held");
    latch_release_a: assert property (
        latch_w && $fell(sync_q) |-> ##[1:6] par_load)
        else $error("no load after latch release");
    hs_edge_a: assert property (hs_edge_s |-> ##1 hs_load_s)
        else $error("handshake edge load timing wrong");
    hs_only_a: assert property (
        hs_w && $past(hs_w) && par_load |-> $past(sync_q, 1) != $past(sync_q, 2))
        else $error("handshake load without strobe edge");
    hs_settle_a: assert property (hs_edge_s |-> ##[1:SETTLE_CYC] par_load)
        else $error("word not ready within settle time");
    word_atomic_a: assert property ($changed(par_word) |-> par_load)
        else $error("word changed outside a load");
endmodule // ppo_port_chk

// >>> bench/ppo_plc_model.sv
module ppo_plc_model #(
    parameter int HALF = 6,
    parameter int SETTLE = 3
) (
    input wire logic sys_clk,
    input wire logic [1:0] mode,
    input wire logic [15:0] par_word,
    output logic par_strobe,
    output logic [15:0] smp_word,
    output logic smp_stb
);
    timeunit 1ns;
    timeprecision 100ps;
    int n = 0;
    // Sampling only after a toggle, else the word from an earlier mode is read
    logic toggled = 1'b0;
    initial
    begin
        par_strobe = 1'b0;
        smp_word = 16'h0000;
        smp_stb = 1'b0;
    end
    // Mode 0 idle low, 1 latch held, 2 square wave
    always @(posedge sys_clk)
    begin
        smp_stb <= 1'b0;
        n <= n + 1;
        if (mode != 2'h2)
        begin
            par_strobe <= mode[0];
            n <= 0;
            toggled <= 1'b0;
        end
        else if (n == HALF - 1)
        begin
            par_strobe <= ~par_strobe;
            n <= 0;
            toggled <= 1'b1;
        end
        else if (n == SETTLE && toggled)
        begin
            smp_word <= par_word;
            smp_stb <= 1'b1;
        end
    end
endmodule // ppo_plc_model

// >>> bench/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int RES = 20;
    localparam int LDT = 50;
    localparam int STL = 3;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic meas_valid = 1'b0;
    logic rd_ph = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [1:0] plc_mode = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] rnd = 32'h4a7b;
    logic [31:0] hrdata;
    logic [31:0] exp_q[$];
    logic [15:0] par_word, smp_word, hs_exp;
    logic hreadyout, hresp, meas_ready, par_strobe, par_load, smp_stb;
    ppo_pkg::ppo_meas_t meas = '0;
    int num_errors = 0;
    int checks = 0;
    int cyc = 0;

    ppo_port #(.RES_REFRESH_CYC(RES), .LDT_REFRESH_CYC(LDT), .SETTLE_CYC(STL)) dut_u (
        .sys_clk(sys_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .meas_valid(meas_valid), .meas(meas),
        .meas_ready(meas_ready), .par_strobe(par_strobe), .par_word(par_word),
        .par_load(par_load)
    );
    ppo_plc_model #(.HALF(6), .SETTLE(STL)) plc_u (
        .sys_clk(sys_clk), .mode(plc_mode), .par_word(par_word), .par_strobe(par_strobe),
        .smp_word(smp_word), .smp_stb(smp_stb)
    );

    initial forever #5 sys_clk = ~sys_clk;

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    function automatic logic [15:0] enc(input logic [1:0] f, input logic [15:0] b);
        logic [15:0] r;
        int x;
        r = (f == 2'h2) ? b ^ (b >> 1) : b;
        x = b;
        if (f == 2'h1)
        begin
            r = 16'h9999;
            for (int i = 0; i < 4 && b < 16'h2710; i++)
            begin
                r[4*i +: 4] = 4'(x % 10);
                x = x / 10;
            end
        end
        return r;
    endfunction

    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Read expectation queued at the address edge, compared by the monitor
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wr ? d : 32'h0;
        if (!wr)
            exp_q.push_back(d);
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
    endtask

    task automatic push(input int n, input logic [15:0] p, input logic [15:0] v);
        meas_valid <= 1'b1;
        for (int i = 0; i < n; i++)
        begin
            meas <= '{pos: p + 16'(i), vel: v};
            do @(posedge sys_clk); while (meas_ready !== 1'b1);
        end
        meas_valid <= 1'b0;
    endtask

    task automatic wload();
        do @(posedge sys_clk); while (par_load !== 1'b1);
    endtask

    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (rd_ph && hreadyout === 1'b1)
            cmp("hrdata", exp_q.pop_front(), hrdata);
        rd_ph <= hsel && htrans[1] && !hwrite && hreadyout === 1'b1;
        if (smp_stb === 1'b1)
            cmp("plc_word", {16'h0, hs_exp}, {16'h0, smp_word});
        if (cyc == 4000)
        begin
            num_errors++;
            print_verdict();
        end
    end

    initial
    begin
        logic [15:0] p, v;
        repeat (10) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        rnd = xs(rnd);
        p = rnd[15:0];
        v = {2'h0, rnd[29:16]};
        push(1, p, v);
        for (int m = 0; m < 6; m++)
        begin
            ahb(1'b1, 8'h00, 32'(m));
            wload();
            wload();
            ahb(1'b0, 8'h08, {16'h0, enc(2'(m >> 1), m[0] ? v : p)});
        end
        ahb(1'b1, 8'h00, 32'h6);
        ahb(1'b0, 8'h00, 32'h0);
        ahb(1'b0, 8'h10, 32'h0);
        ahb(1'b1, 8'h00, 32'h20);
        repeat (4) wload();
        ahb(1'b1, 8'h00, 32'h10);
        plc_mode <= 2'h1;
        repeat (4) @(posedge sys_clk);
        rnd = xs(rnd);
        // Hold stops draining, so two words fill the buffer
        push(2, rnd[15:0], rnd[31:16]);
        repeat (2) @(posedge sys_clk);
        cmp("meas_ready", 32'h0, {31'h0, meas_ready});
        repeat (3 * RES) @(posedge sys_clk);
        ahb(1'b0, 8'h08, {16'h0, p});
        plc_mode <= 2'h0;
        repeat (8) @(posedge sys_clk);
        cmp("meas_ready", 32'h1, {31'h0, meas_ready});
        ahb(1'b0, 8'h08, {16'h0, rnd[15:0] + 16'h1});
        hs_exp = rnd[31:16];
        push(1, hs_exp, 16'h0);
        ahb(1'b1, 8'h00, 32'h18);
        plc_mode <= 2'h2;
        repeat (80) @(posedge sys_clk);
        print_verdict();
    end
endmodule // tb_top

bind ppo_port ppo_port_chk #(
    .RES_REFRESH_CYC(RES_REFRESH_CYC),
    .LDT_REFRESH_CYC(LDT_REFRESH_CYC),
    .SETTLE_CYC(SETTLE_CYC)
) chk_u (
    .sys_clk(sys_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .par_strobe(par_strobe), .par_word(par_word), .par_load(par_load)
);
